/* common/lds_pkg.sv */
// Constants and types for the LED driver sequencer and fault logic
package lds_pkg;
    // Timebase
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_DETECT_US   = 256;
    localparam int T_SOFT_MS     = 128;
    localparam int T_BLANK_MS    = 32;
    localparam int T_LOW_MS      = 32;
    localparam int T_EDGE_US     = 4;
    localparam int T_OPEN_US     = 20;
    localparam int T_SHORT_US    = 2;
    localparam int DETECT_CYC = T_DETECT_US * 1000 / CLK_PERIOD_NS;
    localparam int SOFT_CYC   = T_SOFT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BLANK_CYC  = T_BLANK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int LOW_CYC    = T_LOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int EDGE_CYC   = T_EDGE_US * 1000 / CLK_PERIOD_NS;
    localparam int OPEN_CYC   = T_OPEN_US * 1000 / CLK_PERIOD_NS;
    localparam int SHORT_CYC  = T_SHORT_US * 1000 / CLK_PERIOD_NS;

    localparam int NCH = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

    // Control fields
    localparam int CTRL_FORCE_OFF = 0;
    localparam logic [0:0] CTRL_RESET = 1'h0;

    // Status fields
    localparam int ST_STATE_LSB  = 0;
    localparam int ST_OT         = 4;
    localparam int ST_FEEDBACK   = 5;
    localparam int ST_UNUSED_LSB = 8;

    // Event bits, shared by status and mask
    localparam int EV_OPEN     = 0;
    localparam int EV_SHORT    = 1;
    localparam int EV_OT       = 2;
    localparam int EV_STARTED  = 3;
    localparam int EV_SHUTDOWN = 4;
    localparam int NEV         = 5;
    localparam logic [NEV-1:0] MASK_RESET = 5'h00;

    typedef enum logic [2:0] {
        LDS_OFF,
        LDS_DETECT,
        LDS_SOFT,
        LDS_BLANK,
        LDS_RUN,
        LDS_FAULT
    } lds_state_t;

    // Raw pin inputs, all asynchronous to pclk
    typedef struct packed {
        logic           supply_ok;
        logic           en_pwm;
        logic           ot_hot;
        logic [NCH-1:0] cs_float;
        logic [NCH-1:0] cs_low;
        logic [NCH-1:0] short_hi;
    } lds_pins_t;
endpackage

/* hw/lds_qual_cnt.sv */
// Accumulating qualification counter for one fault class
`timescale 1ns/1ps
module lds_qual_cnt #(
    parameter int LIMIT = 500,
    parameter int W     = 16
) (
    input  wire logic pclk,     // Clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic clr,      // Synchronous clear
    input  wire logic adv,      // Advance one cycle
    output logic      hit       // Accumulated time reached
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (clr) begin
            next_cnt = '0;
        end else if (adv && cnt != W'(LIMIT)) begin
            next_cnt = cnt + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign hit = (cnt == W'(LIMIT));
endmodule

/* hw/lds_top.sv */
// LED driver start sequencer, dimming gate, fault protection, APB regs
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module lds_top #(
    parameter int DETECT_CYC = lds_pkg::DETECT_CYC,
    parameter int SOFT_CYC   = lds_pkg::SOFT_CYC,
    parameter int BLANK_CYC  = lds_pkg::BLANK_CYC,
    parameter int LOW_CYC    = lds_pkg::LOW_CYC,
    parameter int OPEN_CYC   = lds_pkg::OPEN_CYC
) (
    input  wire logic                    pclk,         // Clock 250 MHz
    input  wire logic                    presetn,      // Async reset
    input  wire logic                    psel,         // APB select
    input  wire logic                    penable,      // APB enable
    input  wire logic                    pwrite,       // APB direction
    input  wire logic [7:0]              paddr,        // APB address
    input  wire logic [31:0]             pwdata,       // APB write data
    output logic      [31:0]             prdata,       // APB read data
    output logic                         pready,       // APB ready
    output logic                         pslverr,      // APB error
    input  wire lds_pkg::lds_pins_t      pins,         // Pin inputs
    output logic      [lds_pkg::NCH-1:0] chan_on,      // Sink enables
    output logic                         feedback_max, // Feedback forced
    output logic                         switch_en,    // Switching allowed
    output logic                         fault_o,      // Fault pin level
    output logic                         fault_oe,     // Fault pin drive
    output logic                         irq           // Interrupt
);
    localparam int NCH = lds_pkg::NCH;
    localparam int PW  = $bits(lds_pkg::lds_pins_t);

    // Two-stage synchroniser for every pin
    logic [PW-1:0]      sync1;
    logic [PW-1:0]      sync2;
    lds_pkg::lds_pins_t pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end
    assign pin = lds_pkg::lds_pins_t'(sync2);

    // Sequencer state
    lds_pkg::lds_state_t state;
    lds_pkg::lds_state_t next_state;
    logic [31:0]         phase_cnt;
    logic [31:0]         next_phase_cnt;
    logic [31:0]         low_cnt;
    logic [31:0]         next_low_cnt;
    logic [15:0]         edge_cnt;
    logic [15:0]         next_edge_cnt;
    logic [NCH-1:0]      unused;
    logic [NCH-1:0]      next_unused;
    logic                pwm_d;
    logic                fault_kind;
    logic                next_fault_kind;
    logic                force_off;
    logic                pwm;
    logic                pwm_rise;
    logic                low_done;
    logic                det_on;
    logic                open_adv;
    logic                short_adv;
    logic                open_hit;
    logic                short_hit;
    logic                q_clr;

    assign pwm      = pin.en_pwm;
    assign pwm_rise = pwm && !pwm_d;
    assign low_done = !pwm && low_cnt == 32'(LOW_CYC - 1);
    assign det_on   = state == lds_pkg::LDS_RUN && pwm && !pin.ot_hot
                      && edge_cnt == 16'h0000;
    assign open_adv  = det_on && |(pin.cs_low & ~unused);
    assign short_adv = det_on && |(pin.short_hi & ~unused);
    assign q_clr     = state == lds_pkg::LDS_OFF;

    always_comb begin
        next_state      = state;
        next_phase_cnt  = phase_cnt;
        next_unused     = unused;
        next_fault_kind = fault_kind;
        // Low-time accumulator; shorter lows are dimming off-time
        next_low_cnt = pwm ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
        // Edge blanking reloads on every input rise
        if (pwm_rise) begin
            next_edge_cnt = 16'(lds_pkg::EDGE_CYC);
        end else if (edge_cnt != 16'h0000) begin
            next_edge_cnt = edge_cnt - 16'h0001;
        end else begin
            next_edge_cnt = edge_cnt;
        end
        if (!pin.supply_ok) begin
            next_state     = lds_pkg::LDS_OFF;
            next_phase_cnt = 32'h0000_0000;
            next_low_cnt   = 32'h0000_0000;
            next_edge_cnt  = 16'h0000;
            next_unused    = '0;
        end else if (state != lds_pkg::LDS_OFF && low_done) begin
            next_state     = lds_pkg::LDS_OFF;
            next_phase_cnt = 32'h0000_0000;
            next_edge_cnt  = 16'h0000;
            next_unused    = '0;
        end else begin
            case (state)
                lds_pkg::LDS_OFF: begin
                    next_low_cnt = 32'h0000_0000;
                    if (pwm_rise) begin
                        next_state     = lds_pkg::LDS_DETECT;
                        next_phase_cnt = 32'h0000_0000;
                    end
                end
                lds_pkg::LDS_DETECT: begin
                    next_phase_cnt = phase_cnt + 32'h0000_0001;
                    if (phase_cnt == 32'(DETECT_CYC - 1)) begin
                        next_unused    = pin.cs_float;
                        next_state     = lds_pkg::LDS_SOFT;
                        next_phase_cnt = 32'h0000_0000;
                    end
                end
                lds_pkg::LDS_SOFT: begin
                    next_phase_cnt = phase_cnt + 32'h0000_0001;
                    if (phase_cnt == 32'(SOFT_CYC - 1)) begin
                        next_state     = lds_pkg::LDS_BLANK;
                        next_phase_cnt = 32'h0000_0000;
                    end
                end
                lds_pkg::LDS_BLANK: begin
                    if (pwm) begin
                        next_phase_cnt = phase_cnt + 32'h0000_0001;
                        if (phase_cnt == 32'(BLANK_CYC - 1)) begin
                            next_state     = lds_pkg::LDS_RUN;
                            next_phase_cnt = 32'h0000_0000;
                        end
                    end
                end
                lds_pkg::LDS_RUN: begin
                    if (open_hit || short_hit) begin
                        next_state      = lds_pkg::LDS_FAULT;
                        next_fault_kind = short_hit;
                    end
                end
                default: begin
                    next_state = lds_pkg::LDS_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= lds_pkg::LDS_OFF;
            phase_cnt  <= 32'h0000_0000;
            low_cnt    <= 32'h0000_0000;
            edge_cnt   <= 16'h0000;
            unused     <= '0;
            pwm_d      <= 1'b0;
            fault_kind <= 1'b0;
        end else begin
            state      <= next_state;
            phase_cnt  <= next_phase_cnt;
            low_cnt    <= next_low_cnt;
            edge_cnt   <= next_edge_cnt;
            unused     <= next_unused;
            pwm_d      <= pwm;
            fault_kind <= next_fault_kind;
        end
    end

    lds_qual_cnt #(
        .LIMIT (OPEN_CYC),
        .W     (16)
    ) u_open (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (q_clr),
        .adv     (open_adv),
        .hit     (open_hit)
    );

    lds_qual_cnt #(
        .LIMIT (lds_pkg::SHORT_CYC),
        .W     (16)
    ) u_short (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (q_clr),
        .adv     (short_adv),
        .hit     (short_hit)
    );

    // Pin outputs, registered
    logic           started;
    logic [NCH-1:0] next_chan_on;
    logic           next_feedback_max;
    logic           next_switch_en;
    logic           next_fault_oe;

    assign started = state == lds_pkg::LDS_SOFT
                     || state == lds_pkg::LDS_BLANK
                     || state == lds_pkg::LDS_RUN;

    always_comb begin
        next_chan_on = '0;
        if (started && pwm && !pin.ot_hot && !force_off
            && next_state != lds_pkg::LDS_FAULT
            && next_state != lds_pkg::LDS_OFF) begin
            next_chan_on = ~unused;
        end
        next_feedback_max = state == lds_pkg::LDS_SOFT;
        next_switch_en    = state != lds_pkg::LDS_OFF
                            && pin.supply_ok && !pin.ot_hot;
        next_fault_oe     = state == lds_pkg::LDS_FAULT
                            || (state != lds_pkg::LDS_OFF && pin.ot_hot);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_on      <= '0;
            feedback_max <= 1'b0;
            switch_en    <= 1'b0;
            fault_oe     <= 1'b0;
        end else begin
            chan_on      <= next_chan_on;
            feedback_max <= next_feedback_max;
            switch_en    <= next_switch_en;
            fault_oe     <= next_fault_oe;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_o <= 1'b0;
        end else begin
            fault_o <= 1'b0;
        end
    end

    // APB slave, one wait-free access phase
    logic [lds_pkg::NEV-1:0] irq_stat;
    logic [lds_pkg::NEV-1:0] next_irq_stat;
    logic [lds_pkg::NEV-1:0] irq_mask;
    logic [lds_pkg::NEV-1:0] next_irq_mask;
    logic [lds_pkg::NEV-1:0] events;
    logic                    next_force_off;
    logic [31:0]             next_prdata;
    logic                    next_pready;
    logic                    next_pslverr;
    logic                    setup;
    logic                    wr_now;
    logic                    ot_d;

    assign setup  = psel && !penable;
    assign wr_now = psel && penable && pready && pwrite;

    always_comb begin
        events = '0;
        events[lds_pkg::EV_OPEN]  = state == lds_pkg::LDS_RUN
                                    && next_state == lds_pkg::LDS_FAULT
                                    && !next_fault_kind;
        events[lds_pkg::EV_SHORT] = state == lds_pkg::LDS_RUN
                                    && next_state == lds_pkg::LDS_FAULT
                                    && next_fault_kind;
        events[lds_pkg::EV_OT]    = pin.ot_hot && !ot_d;
        events[lds_pkg::EV_STARTED]  = state == lds_pkg::LDS_BLANK
                                       && next_state == lds_pkg::LDS_RUN;
        events[lds_pkg::EV_SHUTDOWN] = state != lds_pkg::LDS_OFF
                                       && next_state == lds_pkg::LDS_OFF;
    end

    always_comb begin
        next_irq_stat  = irq_stat;
        next_irq_mask  = irq_mask;
        next_force_off = force_off;
        next_prdata    = prdata;
        next_pready    = setup;
        next_pslverr   = 1'b0;
        if (wr_now) begin
            if (paddr == lds_pkg::OFF_CTRL) begin
                next_force_off = pwdata[lds_pkg::CTRL_FORCE_OFF];
            end else if (paddr == lds_pkg::OFF_IRQ_STAT) begin
                next_irq_stat = irq_stat & ~pwdata[lds_pkg::NEV-1:0];
            end else if (paddr == lds_pkg::OFF_IRQ_MASK) begin
                next_irq_mask = pwdata[lds_pkg::NEV-1:0];
            end
        end
        // Hardware set wins over a same-cycle clear
        next_irq_stat = next_irq_stat | events;
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (paddr == lds_pkg::OFF_CTRL) begin
                next_prdata[lds_pkg::CTRL_FORCE_OFF] = force_off;
            end else if (paddr == lds_pkg::OFF_STATUS) begin
                next_prdata[lds_pkg::ST_STATE_LSB +: 3] = state;
                next_prdata[lds_pkg::ST_OT]       = pin.ot_hot;
                next_prdata[lds_pkg::ST_FEEDBACK] = feedback_max;
                next_prdata[lds_pkg::ST_UNUSED_LSB +: NCH] = unused;
            end else if (paddr == lds_pkg::OFF_IRQ_STAT) begin
                next_prdata[lds_pkg::NEV-1:0] = irq_stat;
            end else if (paddr == lds_pkg::OFF_IRQ_MASK) begin
                next_prdata[lds_pkg::NEV-1:0] = irq_mask;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat  <= '0;
            irq_mask  <= lds_pkg::MASK_RESET;
            force_off <= lds_pkg::CTRL_RESET;
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            irq       <= 1'b0;
            ot_d      <= 1'b0;
        end else begin
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            force_off <= next_force_off;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            irq       <= |(next_irq_stat & next_irq_mask);
            ot_d      <= pin.ot_hot;
        end
    end
endmodule

/* verification/lds_top_monitor.sv */
// Concurrent checks on the LED sequencer top ports
`timescale 1ns/1ps
module lds_top_monitor #(
    parameter int LOW_CYC = 40
) (
    input wire logic                    pclk,         // Clock
    input wire logic                    presetn,      // Async reset
    input wire logic                    psel,         // APB select
    input wire logic                    penable,      // APB enable
    input wire logic                    pwrite,       // APB direction
    input wire logic [7:0]              paddr,        // APB address
    input wire logic [31:0]             pwdata,       // APB write data
    input wire logic [31:0]             prdata,       // APB read data
    input wire logic                    pready,       // APB ready
    input wire logic                    pslverr,      // APB error
    input wire lds_pkg::lds_pins_t      pins,         // Pin inputs
    input wire logic [lds_pkg::NCH-1:0] chan_on,      // Sink enables
    input wire logic                    feedback_max, // Feedback forced
    input wire logic                    switch_en,    // Switching allowed
    input wire logic                    fault_o,      // Fault pin level
    input wire logic                    fault_oe,     // Fault pin drive
    input wire logic                    irq           // Interrupt
);
    int unsigned low_run;
    int unsigned hi_run;
    int unsigned cool_cnt;
    int unsigned dry_cnt;

    // Run lengths of the raw pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run  <= 0;
            hi_run   <= 0;
            cool_cnt <= 0;
            dry_cnt  <= 0;
        end else begin
            low_run  <= pins.en_pwm ? 0 : low_run + 1;
            hi_run   <= pins.en_pwm ? hi_run + 1 : 0;
            cool_cnt <= pins.ot_hot ? 0 : cool_cnt + (cool_cnt < 99);
            dry_cnt  <= !pins.supply_ok ? 0 : dry_cnt + (dry_cnt < 99);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence hot5;
        pins.ot_hot [*5];
    endsequence
    sequence cool5;
        (!pins.ot_hot) [*5];
    endsequence
    sequence dim5;
        (!pins.en_pwm) [*5];
    endsequence

    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    bad_addr_a: assert property (psel && !penable &&
        !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    pwm_gate_a: assert property (dim5 |-> chan_on == '0)
        else $error("channels on while dimming low");
    hot_off_a: assert property (hot5 |-> chan_on == '0 && !switch_en)
        else $error("channels on while overheated");
    supply_off_a: assert property ((!pins.supply_ok) [*5] |->
        chan_on == '0 && !switch_en && !feedback_max && !fault_oe)
        else $error("activity during supply lockout");
    soft_quiet_a: assert property (cool5 ##0 feedback_max |-> !fault_oe)
        else $error("fault during soft start");
    fault_hold_a: assert property ($fell(fault_oe) |->
        $past(low_run, 3) >= LOW_CYC || cool_cnt < 8 || dry_cnt < 8)
        else $error("fault released early");
    edge_blank_a: assert property ($rose(fault_oe) |->
        $past(hi_run, 4) > 1000 || cool_cnt < 8)
        else $error("fault inside edge blanking");
endmodule

bind lds_top lds_top_monitor #(.LOW_CYC(LOW_CYC)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .chan_on(chan_on),
    .feedback_max(feedback_max), .switch_en(switch_en), .fault_o(fault_o),
    .fault_oe(fault_oe), .irq(irq));

/* verification/lds_far_model.sv */
// Host dimming source and string sense comparators
`timescale 1ns/1ps
module lds_far_model (
    input  wire logic       pclk,     // Clock
    input  wire logic       en,       // Dimming level wanted
    input  wire logic       hot,      // Die above trip
    input  wire logic       sup,      // Supply above lockout
    input  wire logic [7:0] unused,   // Floating channels
    input  wire logic [7:0] open_ch,  // Broken strings
    input  wire logic [7:0] short_ch, // Shorted strings
    output lds_pkg::lds_pins_t pins   // Pin levels
);
    // Sense reads low on floating strings and whenever en is low
    always @(posedge pclk) begin
        pins.supply_ok <= sup;
        pins.en_pwm    <= en;
        pins.ot_hot    <= hot;
        pins.cs_float  <= unused;
        pins.cs_low    <= open_ch | unused | {8{~en}};
        pins.short_hi  <= short_ch;
    end
endmodule

/* verification/test_led_driver_sequencer_fault.sv */
// Self-checking bench for the LED sequencer top
`timescale 1ns/1ps
module test_led_driver_sequencer_fault;
    localparam int DET  = 20;
    localparam int SOFT = 30;
    localparam int LOW  = 40;
    localparam int OPEN = 50;
    logic               pclk     = 1'b0;
    logic               presetn  = 1'b0;
    logic               psel     = 1'b0;
    logic               penable  = 1'b0;
    logic               pwrite   = 1'b0;
    logic [7:0]         paddr    = 8'h00;
    logic [31:0]        pwdata   = 32'h0;
    logic               en       = 1'b0;
    logic               hot      = 1'b0;
    logic               sup      = 1'b0;
    logic [7:0]         unused   = 8'h00;
    logic [7:0]         open_ch  = 8'h00;
    logic [7:0]         short_ch = 8'h00;
    logic [31:0]        prdata;
    logic               pready, pslverr, feedback_max, switch_en;
    logic               fault_o, fault_oe, irq;
    logic [7:0]         chan_on;
    lds_pkg::lds_pins_t pins;
    int                 bad_count = 0;
    int                 checked   = 0;
    int                 cyc       = 0;
    int                 n;

    always #2 pclk = ~pclk;

    lds_far_model u_far (.pclk(pclk), .en(en), .hot(hot), .sup(sup),
        .unused(unused), .open_ch(open_ch), .short_ch(short_ch),
        .pins(pins));
    lds_top #(.DETECT_CYC(DET), .SOFT_CYC(SOFT), .BLANK_CYC(20),
        .LOW_CYC(LOW), .OPEN_CYC(OPEN)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins),
        .chan_on(chan_on), .feedback_max(feedback_max),
        .switch_en(switch_en), .fault_o(fault_o), .fault_oe(fault_oe),
        .irq(irq));

    task automatic stop_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch at %0t: count %0d", $time, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, a, 32'h0, rd, err);
        chk(rd & m, exp);
        chk({31'h0, err}, {31'h0, eerr});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, d, rd, err);
    endtask
    // Pin outputs sampled mid-cycle
    task automatic look(input logic [7:0] ch, input logic sw,
        input logic fo, input logic ir);
        @(negedge pclk);
        chk({20'h0, fault_o, chan_on, switch_en, fault_oe, irq},
            {20'h0, 1'b0, ch, sw, fo, ir});
        @(posedge pclk);
    endtask
    task automatic wait_for(input int sel, output int k);
        logic hit;
        k = 0;
        hit = 1'b0;
        while (!hit && k < 3000) begin
            @(negedge pclk);
            k++;
            case (sel)
                0: hit = (feedback_max === 1'b1);
                1: hit = (fault_oe === 1'b1);
                default: hit = (feedback_max === 1'b0);
            endcase
        end
        @(posedge pclk);
    endtask
    task automatic pulse(input int hi, input int lo);
        en <= 1'b1;
        tick(hi);
        en <= 1'b0;
        tick(lo);
    endtask

    initial begin
        tick(6);
        presetn <= 1'b1;
        tick(1);
        rd_chk(8'h04, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0, 1'b0);
        rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0, 1'b1);
        wr(8'h04, 32'hFFFF_FFFF);
        rd_chk(8'h04, 32'hFFFF_FFFF, 32'h0, 1'b0);
        wr(8'h00, 32'h1);
        rd_chk(8'h00, 32'h1, 32'h1, 1'b0);
        wr(8'h00, 32'h0);
        sup <= 1'b1;
        unused <= 8'h80;
        tick(3);
        en <= 1'b1;
        wait_for(0, n);
        chk_in(n, DET, DET + 8);
        look(8'h7F, 1'b1, 1'b0, 1'b0);
        en <= 1'b0;
        wait_for(2, n);
        chk_in(n, SOFT - 1, SOFT - 1);
        short_ch <= 8'h01;
        repeat (3) pulse(5, 10);
        rd_chk(8'h04, 32'hFFFF, 32'h8003, 1'b0);
        look(8'h00, 1'b1, 1'b0, 1'b0);
        short_ch <= 8'h00;
        pulse(6, 2);
        en <= 1'b1;
        rd_chk(8'h04, 32'hFFFF, 32'h8004, 1'b0);
        rd_chk(8'h08, 32'h1F, 32'h08, 1'b0);
        look(8'h7F, 1'b1, 1'b0, 1'b0);
        wr(8'h0C, 32'h1F);
        look(8'h7F, 1'b1, 1'b0, 1'b1);
        wr(8'h08, 32'h08);
        look(8'h7F, 1'b1, 1'b0, 1'b0);
        en <= 1'b0;
        tick(5);
        look(8'h00, 1'b1, 1'b0, 1'b0);
        en <= 1'b1;
        tick(4);
        look(8'h7F, 1'b1, 1'b0, 1'b0);
        wr(8'h00, 32'h1);
        look(8'h00, 1'b1, 1'b0, 1'b0);
        wr(8'h00, 32'h0);
        hot <= 1'b1;
        tick(5);
        look(8'h00, 1'b0, 1'b1, 1'b1);
        rd_chk(8'h04, 32'hFFFF, 32'h8014, 1'b0);
        hot <= 1'b0;
        tick(5);
        look(8'h7F, 1'b1, 1'b0, 1'b1);
        wr(8'h08, 32'h04);
        en <= 1'b0;
        tick(5);
        en <= 1'b1;
        short_ch <= 8'h01;
        tick(1300);
        en <= 1'b0;
        look(8'h7F, 1'b1, 1'b0, 1'b0);
        tick(5);
        en <= 1'b1;
        wait_for(1, n);
        chk_in(n, 1197, 1208);
        look(8'h00, 1'b1, 1'b1, 1'b1);
        en <= 1'b0;
        tick(10);
        en <= 1'b1;
        short_ch <= 8'h00;
        tick(5);
        look(8'h00, 1'b1, 1'b1, 1'b1);
        en <= 1'b0;
        tick(LOW - 10);
        rd_chk(8'h04, 32'h7, 32'h5, 1'b0);
        tick(15);
        rd_chk(8'h04, 32'h7, 32'h0, 1'b0);
        look(8'h00, 1'b0, 1'b0, 1'b1);
        wr(8'h08, 32'h1F);
        look(8'h00, 1'b0, 1'b0, 1'b0);
        en <= 1'b1;
        tick(1100);
        rd_chk(8'h04, 32'h7, 32'h4, 1'b0);
        open_ch <= 8'h02;
        wait_for(1, n);
        chk_in(n, OPEN, OPEN + 6);
        look(8'h00, 1'b1, 1'b1, 1'b1);
        rd_chk(8'h08, 32'h1, 32'h1, 1'b0);
        sup <= 1'b0;
        tick(5);
        look(8'h00, 1'b0, 1'b0, 1'b1);
        rd_chk(8'h04, 32'h7, 32'h0, 1'b0);
        stop_test();
    end
endmodule
